// [core/fwp_pkg.sv]
// Constants and types shared by the flash write-protection block
package fwp_pkg;
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned POWER_UP_WAIT_US = 2500;
    localparam int unsigned POWER_UP_WAIT_CYC = POWER_UP_WAIT_US * CLK_MHZ;
    localparam int CNT_W = 17;

    localparam logic [22:0] ARRAY_TOP = 23'h7FFFFF;
    localparam logic [22:0] SIZE_4K = 23'h001000;
    localparam logic [22:0] SIZE_32K = 23'h008000;
    localparam logic [22:0] SIZE_64K = 23'h010000;
    localparam logic [22:0] SIZE_128K = 23'h020000;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] SR_WR_MASK = 16'h447C;
    localparam int SR_WEL = 1;
    localparam int SR_BP_LSB = 2;
    localparam int SR_WPS = 10;
    localparam int SR_INV = 14;

    localparam int NUM_UNITS = 158;
    localparam logic [7:0] BLOCK_UNIT_OFS = 8'h0F;
    localparam logic [7:0] TOP_UNIT_BASE = 8'h8E;
    localparam logic [7:0] EDGE_UNITS = 8'h10;

    localparam logic [7:0] CMD_WRITE_ALLOW = 8'h06;
    localparam logic [7:0] CMD_WRITE_DENY = 8'h04;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] CMD_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_ERASE_4K = 8'h20;
    localparam logic [7:0] CMD_ERASE_32K = 8'h52;
    localparam logic [7:0] CMD_ERASE_64K = 8'hD8;
    localparam logic [7:0] CMD_ERASE_CHIP = 8'hC7;
    localparam logic [7:0] CMD_DEEP_PD = 8'hB9;
    localparam logic [7:0] CMD_RELEASE_PD = 8'hAB;
    localparam logic [7:0] CMD_LOCK_UNIT = 8'h36;
    localparam logic [7:0] CMD_UNLOCK_UNIT = 8'h39;
    localparam logic [7:0] CMD_LOCK_ALL = 8'h7E;
    localparam logic [7:0] CMD_UNLOCK_ALL = 8'h98;

    typedef enum logic [0:0] {
        FWP_STANDBY = 1'b0,
        FWP_RECEIVE = 1'b1
    } fwp_state_e;

    typedef enum logic [2:0] {
        FWP_OP_PROGRAM = 3'b000,
        FWP_OP_ERASE_4K = 3'b001,
        FWP_OP_ERASE_32K = 3'b010,
        FWP_OP_ERASE_64K = 3'b011,
        FWP_OP_ERASE_CHIP = 3'b100
    } fwp_op_e;
endpackage

// [core/fwp_range_dec.sv]
// Protect-level decoder: five level bits plus invert to one address range
`timescale 1ns/1ps
module fwp_range_dec
    import fwp_pkg::*;
(
    input wire logic [4:0] level,
    input wire logic invert,
    output logic prot_none,
    output logic [22:0] prot_lo,
    output logic [22:0] prot_hi
);
    logic [2:0] code;
    logic top;
    logic [22:0] size;
    logic [22:0] base_lo;
    logic [22:0] base_hi;
    logic b_none;
    logic b_all;

    always_comb
    begin
        code = level[2:0];
        top = ~level[3];
        b_none = (code == 3'b000);
        b_all = (code == 3'b111);
        if (!level[4])
        begin
            size = SIZE_128K << (code - 3'd1); // [R9]
        end
        else if (code[2])
        begin
            size = SIZE_32K; // [R11]
        end
        else
        begin
            size = SIZE_4K << (code - 3'd1); // [R11]
        end
        base_lo = top ? (ARRAY_TOP - (size - 23'd1)) : 23'd0;
        base_hi = top ? ARRAY_TOP : (size - 23'd1);
        if (b_all)
        begin
            base_lo = 23'd0; // [R9]
            base_hi = ARRAY_TOP;
        end
        // Complement of a range pinned to one end is pinned to the other
        prot_none = 1'b0;
        prot_lo = base_lo;
        prot_hi = base_hi;
        if (!invert)
        begin
            prot_none = b_none; // [R9]
        end
        else if (b_none)
        begin
            prot_lo = 23'd0; // [R10]
            prot_hi = ARRAY_TOP;
        end
        else if (b_all)
        begin
            prot_none = 1'b1; // [R10]
        end
        else if (top)
        begin
            prot_lo = 23'd0; // [R10]
            prot_hi = base_lo - 23'd1;
        end
        else
        begin
            prot_lo = base_hi + 23'd1; // [R10]
            prot_hi = ARRAY_TOP;
        end
    end
endmodule

// [core/fwp_write_protect.sv]
// Write-protection front end of a serial NOR flash
// What this block does
// [R1] Power-up puts command machine in standby
// [R2] Contents change only after complete valid sequence
// [R3] Reject commands not ending on byte boundary
// [R4] Data-changing commands need write latch set
// [R5] Protect-level range is read-only
// [R6] Deep power-down ignores all but release
// [R7] Delivered: array reads FF, status 00
// [R8] Host waits 2.5 ms after power-up
// [R9] Plain decode: none, all, or doubling range
// [R10] Invert bit protects the exact complement
// [R11] Top level bit selects small sector ranges
// [R12] Erase or program touching protection ignored
// [R13] Scheme select bit picks lock bits instead
// [R14] All lock bits set after power-up
`timescale 1ns/1ps
module fwp_write_protect
    import fwp_pkg::*;
#(
    parameter int unsigned PWR_WAIT_CYC = POWER_UP_WAIT_CYC
)(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    output logic [15:0] status,
    output logic write_latch,
    output logic op_start,
    output logic [2:0] op_kind,
    output logic [22:0] op_addr,
    output logic cmd_reject,
    output logic deep_pd,
    output logic standby,
    output logic power_ready,
    output logic [7:0] erased_fill
);
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic sclk_prev_r;
    logic cs_prev_r;
    logic [CNT_W-1:0] pwr_cnt_r;
    logic power_ready_r;
    fwp_state_e state_r;
    logic standby_r;
    logic [2:0] bit_cnt_r;
    logic [2:0] byte_cnt_r;
    logic [6:0] shift_r;
    logic [7:0] cmd_r;
    logic [23:0] addr_r;
    logic [15:0] status_r;
    logic [NUM_UNITS-1:0] lock_r;
    logic dpd_r;
    logic op_start_r;
    fwp_op_e op_kind_r;
    logic [22:0] op_addr_r;
    logic cmd_reject_r;
    logic [7:0] erased_fill_r;

    logic sclk_rise;
    logic cs_rise;
    logic cs_fall;
    logic rx_end;
    logic [7:0] new_byte;
    logic known;
    logic len_ok;
    logic needs_wel;
    logic range_chk;
    logic is_op;
    fwp_op_e kind;
    logic [22:0] t_lo;
    logic [22:0] t_hi;
    logic dec_none;
    logic [22:0] dec_lo;
    logic [22:0] dec_hi;
    logic lock_hit;
    logic range_hit;
    logic dpd_block;
    logic accept;

    function automatic logic [7:0] unit_of(input logic [22:0] a);
        if (a[22:16] == 7'h00)
            return {4'h0, a[15:12]};
        else if (a[22:16] == 7'h7F)
            return TOP_UNIT_BASE + {4'h0, a[15:12]};
        else
            return BLOCK_UNIT_OFS + {1'b0, a[22:16]};
    endfunction

    function automatic logic [22:0] unit_lo(input logic [7:0] i);
        logic [7:0] d;
        d = i - TOP_UNIT_BASE;
        if (i < EDGE_UNITS)
            return {7'h00, i[3:0], 12'h000};
        else if (i >= TOP_UNIT_BASE)
            return {7'h7F, d[3:0], 12'h000};
        else
            return {7'(i - BLOCK_UNIT_OFS), 16'h0000};
    endfunction

    // Pins come from the host's domain
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_meta_r <= 3'b100;
            pin_sync_r <= 3'b100;
            sclk_prev_r <= 1'b0;
            cs_prev_r <= 1'b1;
        end
        else
        begin
            pin_meta_r <= {cs_n, sclk, mosi};
            pin_sync_r <= pin_meta_r;
            sclk_prev_r <= pin_sync_r[1];
            cs_prev_r <= pin_sync_r[2];
        end
    end

    assign sclk_rise = pin_sync_r[1] & ~sclk_prev_r & ~pin_sync_r[2];
    assign cs_rise = pin_sync_r[2] & ~cs_prev_r;
    assign cs_fall = ~pin_sync_r[2] & cs_prev_r;
    assign rx_end = cs_rise && (state_r == FWP_RECEIVE);
    assign new_byte = {shift_r, pin_sync_r[0]};

    // Selections before the supply settles are not honoured
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pwr_cnt_r <= '0;
            power_ready_r <= 1'b0;
        end
        else if (!power_ready_r)
        begin
            if (pwr_cnt_r == CNT_W'(PWR_WAIT_CYC - 1))
                power_ready_r <= 1'b1; // [R8]
            else
                pwr_cnt_r <= pwr_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= FWP_STANDBY; // [R1]
            standby_r <= 1'b1;
        end
        else if (cs_rise || pin_sync_r[2])
        begin
            state_r <= FWP_STANDBY;
            standby_r <= 1'b1;
        end
        else if (cs_fall && power_ready_r)
        begin
            state_r <= FWP_RECEIVE;
            standby_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bit_cnt_r <= 3'd0;
            byte_cnt_r <= 3'd0;
            shift_r <= 7'h00;
            cmd_r <= 8'h00;
            addr_r <= 24'h000000;
        end
        else if (state_r == FWP_STANDBY)
        begin
            bit_cnt_r <= 3'd0;
            byte_cnt_r <= 3'd0;
        end
        else if (sclk_rise)
        begin
            shift_r <= new_byte[6:0];
            bit_cnt_r <= bit_cnt_r + 3'd1;
            if (bit_cnt_r == 3'd7)
            begin
                if (byte_cnt_r != 3'd7)
                    byte_cnt_r <= byte_cnt_r + 3'd1;
                if (byte_cnt_r == 3'd0)
                    cmd_r <= new_byte;
                else if (byte_cnt_r <= 3'd3)
                    addr_r <= {addr_r[15:0], new_byte};
            end
        end
    end

    always_comb
    begin
        known = 1'b1;
        len_ok = 1'b0;
        needs_wel = 1'b1;
        range_chk = 1'b0;
        is_op = 1'b0;
        kind = FWP_OP_PROGRAM;
        t_lo = addr_r[22:0];
        t_hi = addr_r[22:0];
        case (cmd_r)
            CMD_WRITE_ALLOW, CMD_WRITE_DENY, CMD_DEEP_PD:
            begin
                len_ok = (byte_cnt_r == 3'd1);
                needs_wel = 1'b0;
            end
            CMD_RELEASE_PD:
            begin
                // An empty frame must not replay a stale release opcode
                len_ok = (byte_cnt_r != 3'd0);
                needs_wel = 1'b0;
            end
            CMD_WRITE_STATUS: len_ok = (byte_cnt_r == 3'd3);
            CMD_LOCK_UNIT, CMD_UNLOCK_UNIT: len_ok = (byte_cnt_r == 3'd4);
            CMD_LOCK_ALL, CMD_UNLOCK_ALL: len_ok = (byte_cnt_r == 3'd1);
            CMD_PROGRAM:
            begin
                len_ok = (byte_cnt_r >= 3'd5);
                range_chk = 1'b1;
                is_op = 1'b1;
            end
            CMD_ERASE_4K, CMD_ERASE_32K, CMD_ERASE_64K:
            begin
                len_ok = (byte_cnt_r == 3'd4);
                range_chk = 1'b1;
                is_op = 1'b1;
                kind = (cmd_r == CMD_ERASE_4K) ? FWP_OP_ERASE_4K :
                       (cmd_r == CMD_ERASE_32K) ? FWP_OP_ERASE_32K : FWP_OP_ERASE_64K;
                t_lo = addr_r[22:0] & ~(((cmd_r == CMD_ERASE_4K) ? SIZE_4K :
                       (cmd_r == CMD_ERASE_32K) ? SIZE_32K : SIZE_64K) - 23'd1);
                t_hi = t_lo | (((cmd_r == CMD_ERASE_4K) ? SIZE_4K :
                       (cmd_r == CMD_ERASE_32K) ? SIZE_32K : SIZE_64K) - 23'd1);
            end
            CMD_ERASE_CHIP:
            begin
                len_ok = (byte_cnt_r == 3'd1);
                range_chk = 1'b1;
                is_op = 1'b1;
                kind = FWP_OP_ERASE_CHIP;
                t_lo = 23'd0;
                t_hi = ARRAY_TOP;
            end
            default: known = 1'b0;
        endcase
    end

    fwp_range_dec u_dec (
        .level(status_r[SR_BP_LSB+4:SR_BP_LSB]),
        .invert(status_r[SR_INV]),
        .prot_none(dec_none),
        .prot_lo(dec_lo),
        .prot_hi(dec_hi)
    );

    // Full scan is wide but keeps a multi-unit erase exact
    always_comb
    begin
        lock_hit = 1'b0;
        for (int i = 0; i < NUM_UNITS; i++)
        begin
            if (lock_r[i] && unit_lo(8'(i)) <= t_hi &&
                (unit_lo(8'(i)) | ((8'(i) < EDGE_UNITS || 8'(i) >= TOP_UNIT_BASE) ?
                 (SIZE_4K - 23'd1) : (SIZE_64K - 23'd1))) >= t_lo)
                lock_hit = 1'b1;
        end
    end

    assign range_hit = status_r[SR_WPS] ? lock_hit : // [R13]
                       (!dec_none && t_lo <= dec_hi && t_hi >= dec_lo); // [R5] [R12]
    assign dpd_block = dpd_r && (cmd_r != CMD_RELEASE_PD); // [R6]
    assign accept = rx_end && !dpd_block && known && len_ok && bit_cnt_r == 3'd0 && // [R2] [R3]
                    (!needs_wel || status_r[SR_WEL]) && !(range_chk && range_hit); // [R4]

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            status_r <= STATUS_RESET; // [R7]
        else if (accept)
        begin
            if (cmd_r == CMD_WRITE_ALLOW)
                status_r[SR_WEL] <= 1'b1; // [R4]
            else if (cmd_r == CMD_WRITE_STATUS)
                status_r <= {addr_r[7:0], addr_r[15:8]} & SR_WR_MASK;
            else if (cmd_r == CMD_WRITE_DENY || needs_wel)
                status_r[SR_WEL] <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            lock_r <= '1; // [R14]
        else if (accept)
        begin
            if (cmd_r == CMD_LOCK_ALL)
                lock_r <= '1;
            else if (cmd_r == CMD_UNLOCK_ALL)
                lock_r <= '0;
            else if (cmd_r == CMD_LOCK_UNIT || cmd_r == CMD_UNLOCK_UNIT)
                lock_r[unit_of(addr_r[22:0])] <= (cmd_r == CMD_LOCK_UNIT);
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            dpd_r <= 1'b0;
        else if (accept && cmd_r == CMD_DEEP_PD)
            dpd_r <= 1'b1;
        else if (accept && cmd_r == CMD_RELEASE_PD)
            dpd_r <= 1'b0; // [R6]
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            op_start_r <= 1'b0;
            op_kind_r <= FWP_OP_PROGRAM;
            op_addr_r <= 23'd0;
            cmd_reject_r <= 1'b0;
            erased_fill_r <= ERASED_BYTE; // [R7]
        end
        else
        begin
            op_start_r <= accept && is_op; // [R2]
            cmd_reject_r <= rx_end && !dpd_block && !accept; // [R3]
            if (accept && is_op)
            begin
                op_kind_r <= kind;
                op_addr_r <= t_lo;
            end
        end
    end

    assign status = status_r;
    assign write_latch = status_r[SR_WEL];
    assign op_start = op_start_r;
    assign op_kind = op_kind_r;
    assign op_addr = op_addr_r;
    assign cmd_reject = cmd_reject_r;
    assign deep_pd = dpd_r;
    assign standby = standby_r;
    assign power_ready = power_ready_r;
    assign erased_fill = erased_fill_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_standby_when_idle: assert property (pin_sync_r[2] && cs_prev_r |=> state_r == FWP_STANDBY) // [R1]
        else $error("not in standby while deselected");
    a_op_full_seq: assert property (op_start_r |-> $past(rx_end) && $past(bit_cnt_r) == 3'd0) // [R2]
        else $error("operation without complete sequence");
    a_byte_boundary: assert property (rx_end && !dpd_block && bit_cnt_r != 3'd0 // [R3]
        |=> cmd_reject_r && !op_start_r)
        else $error("partial byte not rejected");
    a_op_needs_latch: assert property (op_start_r |-> $past(status_r[SR_WEL]) && !status_r[SR_WEL]) // [R4]
        else $error("operation without write latch");
    a_prot_refused: assert property (rx_end && range_chk && range_hit |=> !op_start_r) // [R12]
        else $error("protected target accepted");
    a_read_only_range: assert property (rx_end && !status_r[SR_WPS] && !dec_none && range_chk && // [R5]
        addr_r[22:0] >= dec_lo && addr_r[22:0] <= dec_hi |=> !op_start_r)
        else $error("write inside protected range");
    a_dpd_ignore: assert property (dpd_r && rx_end && cmd_r != CMD_RELEASE_PD // [R6]
        |=> !op_start_r && !cmd_reject_r && dpd_r)
        else $error("command honoured in deep power-down");
    a_delivery_state: assert property (!power_ready_r // [R7]
        |-> status_r == STATUS_RESET && erased_fill_r == ERASED_BYTE)
        else $error("delivery state wrong");
    a_wait_power: assert property (!power_ready_r |-> state_r == FWP_STANDBY) // [R8]
        else $error("selected before power-up wait");
    a_none_code: assert property (status_r[SR_BP_LSB+2:SR_BP_LSB] == 3'b000 && !status_r[SR_INV] // [R9]
        |-> dec_none)
        else $error("code 000 protects something");
    a_invert_all: assert property (status_r[SR_BP_LSB+2:SR_BP_LSB] == 3'b000 && status_r[SR_INV] // [R10]
        |-> !dec_none && dec_lo == 23'd0 && dec_hi == ARRAY_TOP)
        else $error("inverted code 000 not all");
    a_small_top: assert property (status_r[SR_BP_LSB+4:SR_BP_LSB] == 5'b10001 && !status_r[SR_INV] // [R11]
        |-> dec_lo == 23'h7FF000 && dec_hi == ARRAY_TOP)
        else $error("4KB top range wrong");
    a_lock_scheme: assert property (rx_end && status_r[SR_WPS] && range_chk && lock_hit |=> !op_start_r) // [R13]
        else $error("locked unit written");
    a_locks_held: assert property (!power_ready_r |-> &lock_r) // [R14]
        else $error("lock bits not set after power-up");

    c_op_start: cover property (op_start_r);
    c_reject: cover property (cmd_reject_r);
    c_enter_dpd: cover property ($rose(dpd_r));
endmodule

// [test/fwp_host_model.sv]
// SPI host model that sends command frames to the flash front end
`timescale 1ns/1ps
module fwp_host_model
(
    input wire logic clk,
    output logic cs_n,
    output logic sclk,
    output logic mosi
);
    localparam int HALF = 3;

    initial
    begin
        cs_n <= 1'b1;
        sclk <= 1'b0;
        mosi <= 1'b0;
    end

    // Chip select stays idle through the power-up wait
    task automatic power_wait(input int cyc);
        repeat (cyc) @(posedge clk);
    endtask

    // MSB first; a bit count off a multiple of 8 leaves a partial byte
    task automatic send(input logic [7:0] b [6], input int nbits);
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (HALF) @(posedge clk);
        for (int k = 0; k < nbits; k++)
        begin
            mosi <= b[k / 8][7 - k % 8];
            sclk <= 1'b0;
            repeat (HALF) @(posedge clk);
            sclk <= 1'b1;
            repeat (HALF) @(posedge clk);
        end
        sclk <= 1'b0;
        repeat (HALF) @(posedge clk);
        cs_n <= 1'b1;
        // Released data line flips, so a stale bit is never mistaken for data
        mosi <= ~mosi;
    endtask
endmodule

// [test/fwp_write_protect_tb.sv]
// Self-checking bench for the flash write-protection front end
`timescale 1ns/1ps
module fwp_write_protect_tb
    import fwp_pkg::*;
;
    localparam int unsigned PWR = 8;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic [15:0] status;
    logic write_latch;
    logic op_start;
    logic [2:0] op_kind;
    logic [22:0] op_addr;
    logic cmd_reject;
    logic deep_pd;
    logic standby;
    logic power_ready;
    logic [7:0] erased_fill;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] fr [6];
    logic [1:0] res;
    logic [2:0] res_kind;
    logic [22:0] res_addr;
    int m_status = 0;
    int m_locked = 1;
    int m_open = -1;

    always #12.5 clk = ~clk;

    fwp_host_model i_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));

    fwp_write_protect #(.PWR_WAIT_CYC(PWR)) i_dut (.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk),
        .mosi(mosi), .status(status), .write_latch(write_latch), .op_start(op_start), .op_kind(op_kind),
        .op_addr(op_addr), .cmd_reject(cmd_reject), .deep_pd(deep_pd), .standby(standby),
        .power_ready(power_ready), .erased_fill(erased_fill));

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Run takes about 34k cycles; hang guard well above that
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 70000)
        begin
            failures++;
            close_out();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Outcome: 0 nothing, 1 operation started, 2 refused
    task automatic xfer(input int nbits, input logic [1:0] exp);
        i_host.send(fr, nbits);
        res = 2'd0;
        repeat (8)
        begin
            @(posedge clk);
            #1;
            if (op_start === 1'b1)
            begin
                res = 2'd1;
                res_kind = op_kind;
                res_addr = op_addr;
            end
            if (cmd_reject === 1'b1)
                res = 2'd2;
        end
        chk("outcome", 32'(res), 32'(exp));
    endtask

    task automatic cmd1(input logic [7:0] op, input logic [1:0] exp);
        fr[0] = op;
        xfer(8, exp);
    endtask

    task automatic allow();
        cmd1(CMD_WRITE_ALLOW, 2'd0);
        chk("latch", 32'(write_latch), 1);
    endtask

    // Per-unit lock or unlock, opcode plus three address bytes
    task automatic lock_cmd(input logic [7:0] op, input int a);
        allow();
        fr[0] = op;
        fr[1] = 8'(a >> 16);
        fr[2] = 8'(a >> 8);
        fr[3] = 8'(a);
        xfer(32, 2'd0);
    endtask

    // Reference decode of the protected range
    function automatic bit hit(input int a, input int len);
        int lv;
        int n;
        int sz;
        int lo;
        int hi;
        bit none;
        if ((m_status >> SR_WPS) & 1)
            return m_locked != 0 && !((a >> 16) == m_open && len <= 32'h10000);
        lv = (m_status >> SR_BP_LSB) & 31;
        n = lv & 7;
        sz = (lv & 16) ? ((n > 3) ? 32'h8000 : 32'h800 << n) : 32'h10000 << n;
        none = (n == 0);
        lo = (lv & 8) ? 0 : 32'h800000 - sz;
        hi = lo + sz - 1;
        if (n == 7)
        begin
            lo = 0;
            hi = 32'h7FFFFF;
        end
        if ((m_status >> SR_INV) & 1)
        begin
            if (none)
            begin
                lo = 0;
                hi = 32'h7FFFFF;
            end
            if (n == 7)
                none = 1'b1;
            else if (!none && lo == 0)
            begin
                lo = hi + 1;
                hi = 32'h7FFFFF;
            end
            else if (!none)
            begin
                hi = lo - 1;
                lo = 0;
            end
            if (n == 0)
                none = 1'b0;
        end
        return !none && a <= hi && a + len - 1 >= lo;
    endfunction

    task automatic wr_status(input int v);
        allow();
        fr[0] = CMD_WRITE_STATUS;
        fr[1] = 8'(v);
        fr[2] = 8'(v >> 8);
        xfer(24, 2'd0);
        m_status = v & int'(SR_WR_MASK);
        chk("status", 32'(status), m_status);
        chk("latch", 32'(write_latch), 0);
    endtask

    // Program (k=0) or erase kinds 1..4; en says whether the latch was set
    task automatic do_op(input int k, input int a, input bit en);
        int len;
        int al;
        bit p;
        len = k == 0 ? 1 : k == 1 ? 32'h1000 : k == 2 ? 32'h8000 : k == 3 ? 32'h10000 : 32'h800000;
        al = k == 4 ? 0 : a & ~(len - 1);
        fr[0] = k == 0 ? CMD_PROGRAM : k == 1 ? CMD_ERASE_4K : k == 2 ? CMD_ERASE_32K :
            k == 3 ? CMD_ERASE_64K : CMD_ERASE_CHIP;
        fr[1] = 8'(al >> 16);
        fr[2] = 8'(al >> 8);
        fr[3] = 8'(al);
        fr[4] = 8'($urandom);
        p = hit(al, len) || !en;
        xfer(k == 0 ? 40 : k == 4 ? 8 : 32, p ? 2'd2 : 2'd1);
        if (!p)
        begin
            chk("kind", 32'(res_kind), k);
            chk("addr", 32'(res_addr), al);
        end
        chk("latch", 32'(write_latch), p && en);
    endtask

    initial
    begin
        int a;
        fr = '{default: 8'h00};
        void'($urandom(35));
        repeat (5) @(posedge clk);
        chk("status", 32'(status), 32'(STATUS_RESET));
        chk("latch", 32'(write_latch), 0);
        chk("standby", 32'(standby), 1);
        chk("deep_pd", 32'(deep_pd), 0);
        chk("fill", 32'(erased_fill), 32'hFF);
        chk("ready", 32'(power_ready), 0);
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        for (int j = 0; j < 40 && power_ready !== 1'b1; j++)
            @(posedge clk);
        #1;
        chk("ready", 32'(power_ready), 1);
        i_host.power_wait(4);
        $display("test reset done");

        do_op(0, 32'h123456, 1'b0);
        allow();
        fr[0] = CMD_WRITE_DENY;
        xfer(7, 2'd2);
        xfer(9, 2'd2);
        fr[0] = CMD_PROGRAM;
        xfer(39, 2'd2);
        chk("latch", 32'(write_latch), 1);
        cmd1(CMD_WRITE_DENY, 2'd0);
        chk("latch", 32'(write_latch), 0);
        $display("test framing done");

        cmd1(CMD_DEEP_PD, 2'd0);
        chk("deep_pd", 32'(deep_pd), 1);
        cmd1(CMD_WRITE_ALLOW, 2'd0);
        xfer(5, 2'd0);
        chk("latch", 32'(write_latch), 0);
        cmd1(CMD_RELEASE_PD, 2'd0);
        chk("deep_pd", 32'(deep_pd), 0);
        $display("test power down done");

        for (int i = 0; i < 64; i++)
        begin
            wr_status(($urandom & 32'hBB83) | (i % 32) << 2 | (i / 32) << 14);
            a = $urandom % 3;
            a = a == 0 ? $urandom % 32'h20000 : a == 1 ? 32'h7E0000 + $urandom % 32'h20000 : $urandom & 32'h7FFFFF;
            allow();
            do_op(i % 5, a, 1'b1);
        end
        $display("test ranges done");

        wr_status(32'h0400);
        allow();
        do_op(0, $urandom & 32'h7FFFFF, 1'b1);
        allow();
        cmd1(CMD_UNLOCK_ALL, 2'd0);
        m_locked = 0;
        allow();
        do_op(3, $urandom & 32'h7FFFFF, 1'b1);
        allow();
        cmd1(CMD_LOCK_ALL, 2'd0);
        m_locked = 1;
        allow();
        do_op(1, $urandom & 32'h7FFFFF, 1'b1);
        lock_cmd(CMD_UNLOCK_UNIT, 32'h120000);
        m_open = 32'h12;
        allow();
        do_op(3, 32'h12C000, 1'b1);
        allow();
        do_op(0, 32'h130000 + ($urandom & 32'hFFFF), 1'b1);
        lock_cmd(CMD_LOCK_UNIT, 32'h120000);
        m_open = -1;
        allow();
        do_op(0, 32'h120000 + ($urandom & 32'hFFFF), 1'b1);
        $display("test block locks done");
        close_out();
    end
endmodule
